// >>> hw/fhbr_top.sv
// data-link host registers, tx packet/code path and axi4-lite slave
// What this block does
// - Reading register 05 returns the next received packet byte, msb in bit 7.
// - Bits 7..3 of status register 06 are unassigned; here they read zero.
// - Status bit 2 is high live while the tx fifo is empty, bit 1 while full.
// - If the tx fifo runs dry mid-packet with no code pending, an abort is sent and bit 0 set.
// - The underrun flag holds until the host reads register 06.
// - Code bit 6 picks the link pin when 0, the onboard controller when 1.
// - Register 07 is read/write with trigger, source select and code.
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module fhbr_top
	import fhbr_pkg::*;
(
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite write address
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [7:0]  s_axi_awaddr,
	// axi4-lite write data
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	// axi4-lite write response
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	// axi4-lite read address
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [7:0]  s_axi_araddr,
	// axi4-lite read data
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	// data link: bit slot strobe, external pin, outgoing bit
	input  wire logic        link_bit_strobe,
	input  wire logic        link_data_input_pin,
	output logic             link_data_out,
	// interrupt
	output logic             irq
);
	logic        aw_q;
	logic        w_q;
	logic [7:0]  awaddr_q;
	logic [31:0] wdata_q;
	logic        wstrb0_q;
	logic        wr_fire;
	logic        rd_fire;
	logic        rd_hit;
	logic [7:0]  rd_byte;
	logic [7:0]  code_q;
	logic        udr_q;
	logic [2:0]  irq_stat_q;
	logic [2:0]  irq_mask_q;
	logic [1:0]  pin_sync_q;
	logic [1:0]  strobe_sync_q;
	logic        strobe_prev_q;
	logic        slot;
	logic        send_rise;
	logic        code_pend_q;
	logic [7:0]  shift_q;
	logic [3:0]  bitcnt_q;
	logic        ctrl_bit_q;
	logic        in_packet_q;
	logic        tx_empty;
	logic        tx_full;
	logic        rx_empty;
	logic [7:0]  rd_idx;
	logic [7:0]  tx_rdata;
	logic [7:0]  rx_rdata;
	logic        underrun_ev;
	logic        wr_data_ok;
	fhbr_tx_state_type state_q;
	fhbr_fifo_req_type tx_req;
	fhbr_fifo_req_type rx_req;

	// axi handshakes: accept address and data in either order
	assign s_axi_awready = !aw_q && !s_axi_bvalid;
	assign s_axi_wready  = !w_q && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign wr_fire       = aw_q && w_q && !s_axi_bvalid;
	assign rd_fire       = s_axi_arvalid && s_axi_arready;
	assign wr_data_ok    = wr_fire && wstrb0_q;
	assign rd_idx        = {2'b00, s_axi_araddr[7:2]}; // word index of the read

	// write channel capture
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_q     <= 1'b0;
			w_q      <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q  <= 32'h0000_0000;
			wstrb0_q <= 1'b0;
		end else if (wr_fire) begin
			aw_q <= 1'b0;
			w_q  <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_q     <= 1'b1;
				awaddr_q <= {2'b00, s_axi_awaddr[7:2]}; // word index
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_q      <= 1'b1;
				wdata_q  <= s_axi_wdata;
				wstrb0_q <= s_axi_wstrb[0];
			end
		end
	end

	// write response; unmapped addresses answer slverr
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= FHBR_RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (awaddr_q inside {FHBR_IDX_TX_CODE,
				FHBR_IDX_TX_FIFO, FHBR_IDX_IRQ_MASK, FHBR_IDX_RX_PUSH})
				? FHBR_RESP_OKAY : FHBR_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// read decode
	always_comb begin
		rd_hit  = 1'b1;
		rd_byte = 8'h00;
		case (rd_idx)
			FHBR_IDX_RX_FIFO:    rd_byte = rx_rdata;
			FHBR_IDX_TX_STATUS:  rd_byte = {5'h00, tx_empty, tx_full, udr_q};
			FHBR_IDX_TX_CODE:    rd_byte = code_q;
			FHBR_IDX_IRQ_STATUS: rd_byte = {5'h00, irq_stat_q};
			FHBR_IDX_IRQ_MASK:   rd_byte = {5'h00, irq_mask_q};
			default:             rd_hit = 1'b0;
		endcase
	end

	// read data register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= FHBR_RESP_OKAY;
		end else if (rd_fire) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= {24'h00_0000, rd_byte};
			s_axi_rresp  <= rd_hit ? FHBR_RESP_OKAY : FHBR_RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// code control register, read/write
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			code_q <= FHBR_CODE_RST;
		end else if (wr_data_ok && awaddr_q == FHBR_IDX_TX_CODE) begin
			code_q <= wdata_q[7:0];
		end
	end

	// interrupt mask register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_mask_q <= FHBR_MASK_RST;
		end else if (wr_data_ok && awaddr_q == FHBR_IDX_IRQ_MASK) begin
			irq_mask_q <= wdata_q[2:0];
		end
	end

	// fifos: tx loaded by host, rx loaded through the push port
	assign tx_req.push  = wr_data_ok && awaddr_q == FHBR_IDX_TX_FIFO;
	assign tx_req.wdata = wdata_q[7:0];
	assign tx_req.pop   = slot && bitcnt_q == 4'h0 && !code_pend_q
		&& !tx_empty; // pop whenever a data byte starts, from any state
	assign rx_req.push  = wr_data_ok && awaddr_q == FHBR_IDX_RX_PUSH;
	assign rx_req.wdata = wdata_q[7:0];
	assign rx_req.pop   = rd_fire && rd_idx == FHBR_IDX_RX_FIFO;

	fhbr_fifo u_tx_fifo (
		.aclk    (aclk),
		.aresetn (aresetn),
		.req     (tx_req),
		.rdata   (tx_rdata),
		.empty   (tx_empty),
		.full    (tx_full)
	);

	fhbr_fifo u_rx_fifo (
		.aclk    (aclk),
		.aresetn (aresetn),
		.req     (rx_req),
		.rdata   (rx_rdata),
		.empty   (rx_empty),
		.full    ()
	);

	// pin inputs pass two flip-flops
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_sync_q    <= 2'b00;
			strobe_sync_q <= 2'b00;
			strobe_prev_q <= 1'b0;
		end else begin
			pin_sync_q    <= {pin_sync_q[0], link_data_input_pin};
			strobe_sync_q <= {strobe_sync_q[0], link_bit_strobe};
			strobe_prev_q <= strobe_sync_q[1];
		end
	end
	assign slot      = strobe_sync_q[1] && !strobe_prev_q;
	assign send_rise = wr_data_ok && awaddr_q == FHBR_IDX_TX_CODE
		&& !code_q[FHBR_POS_SEND] && wdata_q[FHBR_POS_SEND];

	// pending code request waits for the byte end; dropped as the code starts
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			code_pend_q <= 1'b0;
		end else if (send_rise) begin
			code_pend_q <= 1'b1;
		end else if (slot && bitcnt_q == 4'h0) begin
			code_pend_q <= 1'b0;
		end
	end

	assign underrun_ev = slot && state_q == FHBR_TX_DATA && bitcnt_q == 4'h0
		&& tx_empty && in_packet_q && !code_pend_q;

	// link transmitter: one bit per slot strobe, lsb first
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q     <= FHBR_TX_IDLE;
			shift_q     <= 8'h00;
			bitcnt_q    <= 4'h0;
			ctrl_bit_q  <= 1'b1;
			in_packet_q <= 1'b0;
		end else if (slot) begin
			if (bitcnt_q != 4'h0) begin
				ctrl_bit_q <= shift_q[0];
				shift_q    <= {1'b1, shift_q[7:1]};
				bitcnt_q   <= bitcnt_q - 4'h1;
			end else if (code_pend_q) begin
				state_q    <= FHBR_TX_CODE;
				ctrl_bit_q <= code_q[0];
				shift_q    <= {3'h7, code_q[5:1]};
				bitcnt_q   <= {1'b0, FHBR_CODE_BITS - 3'h1};
				in_packet_q <= 1'b0;
			end else if (!tx_empty) begin
				state_q     <= FHBR_TX_DATA;
				ctrl_bit_q  <= tx_rdata[0];
				shift_q     <= {1'b1, tx_rdata[7:1]};
				bitcnt_q    <= 4'h7;
				in_packet_q <= 1'b1;
			end else if (in_packet_q) begin
				state_q     <= FHBR_TX_ABORT;
				ctrl_bit_q  <= 1'b1;
				shift_q     <= 8'hFF;
				bitcnt_q    <= FHBR_ABORT_BITS - 4'h1;
				in_packet_q <= 1'b0;
			end else begin
				state_q    <= FHBR_TX_IDLE;
				ctrl_bit_q <= 1'b1;
			end
		end
	end

	// underrun flag: set wins over the read clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			udr_q <= 1'b0;
		end else if (underrun_ev) begin
			udr_q <= 1'b1;
		end else if (rd_fire && rd_idx == FHBR_IDX_TX_STATUS) begin
			udr_q <= 1'b0;
		end
	end

	// sticky events: underrun, rx data ready, tx fifo empty
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat_q <= 3'h0;
		end else begin
			irq_stat_q <= ((rd_fire && rd_idx == FHBR_IDX_IRQ_STATUS)
				? 3'h0 : irq_stat_q)
				| {tx_empty, !rx_empty, underrun_ev};
		end
	end

	// link source select and interrupt output
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			link_data_out <= 1'b1;
			irq           <= 1'b0;
		end else begin
			link_data_out <= code_q[FHBR_POS_SRC] ? ctrl_bit_q
				: pin_sync_q[1];
			irq <= |(irq_stat_q & irq_mask_q);
		end
	end

	sequence udr_set_s;
		underrun_ev;
	endsequence
	sequence status_read_s;
		rd_fire && rd_idx == FHBR_IDX_TX_STATUS && !underrun_ev;
	endsequence

	udr_sets_a: assert property (@(posedge aclk) disable iff (!aresetn)
		udr_set_s |=> udr_q) else $error("underrun not latched");
	udr_holds_a: assert property (@(posedge aclk) disable iff (!aresetn)
		udr_q && !(rd_fire && rd_idx == FHBR_IDX_TX_STATUS) |=> udr_q)
		else $error("underrun dropped without read");
	udr_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
		status_read_s |=> !udr_q) else $error("underrun not cleared");
	abort_go_a: assert property (@(posedge aclk) disable iff (!aresetn)
		underrun_ev |=> state_q == FHBR_TX_ABORT && ctrl_bit_q)
		else $error("no abort after underrun");
	status_live_a: assert property (@(posedge aclk) disable iff (!aresetn)
		rd_fire && rd_idx == FHBR_IDX_TX_STATUS |=>
		s_axi_rdata[2:1] == $past({tx_empty, tx_full}) && s_axi_rdata[7:3] == 5'h00)
		else $error("tx status bits wrong");
	rx_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
		rd_fire && rd_idx == FHBR_IDX_RX_FIFO |=>
		s_axi_rdata[7:0] == $past(rx_rdata))
		else $error("rx byte wrong");
	code_rw_a: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_data_ok && awaddr_q == FHBR_IDX_TX_CODE |=> code_q == $past(wdata_q[7:0]))
		else $error("code register not written");
	code_pend_a: assert property (@(posedge aclk) disable iff (!aresetn)
		send_rise |=> code_pend_q) else $error("send code lost");
	source_pin_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!code_q[FHBR_POS_SRC] |=> link_data_out == $past(pin_sync_q[1]))
		else $error("pin source not used");
	code_first_a: assert property (@(posedge aclk) disable iff (!aresetn)
		slot && bitcnt_q == 4'h0 && code_pend_q |=> ctrl_bit_q == $past(code_q[0]))
		else $error("code bit 0 not first");
endmodule // fhbr_top
`default_nettype wire

// >>> hw/fhbr_pkg.sv
// package: register map, field positions and types for the data-link host block
package fhbr_pkg;
	// register indices; the byte address on the bus is four times the index
	localparam logic [7:0] FHBR_IDX_RX_FIFO    = 8'h05;
	localparam logic [7:0] FHBR_IDX_TX_STATUS  = 8'h06;
	localparam logic [7:0] FHBR_IDX_TX_CODE    = 8'h07;
	localparam logic [7:0] FHBR_IDX_TX_FIFO    = 8'h08;
	localparam logic [7:0] FHBR_IDX_IRQ_STATUS = 8'h10;
	localparam logic [7:0] FHBR_IDX_IRQ_MASK   = 8'h11;
	localparam logic [7:0] FHBR_IDX_RX_PUSH    = 8'h12;
	// field positions
	localparam int FHBR_POS_SEND   = 7;
	localparam int FHBR_POS_SRC    = 6;
	localparam int FHBR_POS_EMPTY  = 2;
	localparam int FHBR_POS_FULL   = 1;
	localparam int FHBR_POS_UDR    = 0;
	// reset values
	localparam logic [7:0] FHBR_CODE_RST = 8'h00;
	localparam logic [2:0] FHBR_MASK_RST = 3'h0;
	// fifo geometry
	localparam int FHBR_FIFO_DEPTH = 16;
	localparam int FHBR_PTR_W      = 4;
	localparam logic [4:0] FHBR_FIFO_FULL_CNT = 5'h10;
	// abort: eight ones on the link
	localparam logic [3:0] FHBR_ABORT_BITS = 4'h8;
	localparam logic [2:0] FHBR_CODE_BITS  = 3'h6;
	// bus answers
	localparam logic [1:0] FHBR_RESP_OKAY   = 2'h0;
	localparam logic [1:0] FHBR_RESP_SLVERR = 2'h2;
	// link transmitter modes
	typedef enum logic [1:0] {
		FHBR_TX_IDLE  = 2'b00,
		FHBR_TX_DATA  = 2'b01,
		FHBR_TX_ABORT = 2'b10,
		FHBR_TX_CODE  = 2'b11
	} fhbr_tx_state_type;
	// fifo write/read bundle
	typedef struct packed {
		logic       push;
		logic       pop;
		logic [7:0] wdata;
	} fhbr_fifo_req_type;
endpackage

// >>> hw/fhbr_fifo.sv
// byte fifo in flip-flops with live empty and full flags
`timescale 1ns/10ps
`default_nettype none
module fhbr_fifo
	import fhbr_pkg::*;
(
	// clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// requests
	input  wire fhbr_fifo_req_type req,
	// state
	output logic [7:0]             rdata,
	output logic                   empty,
	output logic                   full
);
	logic [7:0]            mem_q [FHBR_FIFO_DEPTH];
	logic [FHBR_PTR_W-1:0] wptr_q;
	logic [FHBR_PTR_W-1:0] rptr_q;
	logic [FHBR_PTR_W:0]   cnt_q;
	logic                  do_push;
	logic                  do_pop;

	// guard pointers: popping empty or pushing full changes nothing
	assign do_push = req.push && !full;
	assign do_pop  = req.pop && !empty;
	assign empty   = (cnt_q == '0);
	assign full    = (cnt_q == FHBR_FIFO_FULL_CNT);
	assign rdata   = mem_q[rptr_q];

	// storage, one generate entry per slot
	for (genvar i = 0; i < FHBR_FIFO_DEPTH; i++) begin : g_slot
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				mem_q[i] <= 8'h00;
			end else if (do_push && wptr_q == FHBR_PTR_W'(i)) begin
				mem_q[i] <= req.wdata;
			end
		end
	end

	// pointers and fill count
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wptr_q <= '0;
			rptr_q <= '0;
			cnt_q  <= '0;
		end else begin
			if (do_push) wptr_q <= wptr_q + 1'b1;
			if (do_pop) rptr_q <= rptr_q + 1'b1;
			if (do_push && !do_pop) cnt_q <= cnt_q + 1'b1;
			else if (do_pop && !do_push) cnt_q <= cnt_q - 1'b1;
		end
	end

	empty_pop_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(empty && req.pop && !req.push) |=> $stable(rptr_q) && empty)
		else $error("pop of empty fifo moved pointer");
endmodule // fhbr_fifo
`default_nettype wire

// >>> bench/fhbr_link_partner.sv
// far-side model: data-link bit slot strobes, link pin level, bit capture
`timescale 1ns/10ps
`default_nettype none
module fhbr_link_partner (
	// clock
	input  wire logic   aclk,
	// control from the bench
	input  wire logic   run,
	input  wire logic   slow,
	input  wire logic   pin_level,
	// link side
	input  wire logic   link_data_out,
	output logic        link_bit_strobe,
	output logic        link_data_input_pin,
	// captured stream, newest bit in position 0
	output logic [63:0] seen_bits
);
	int cnt = 0;

	// external pin level is set by the bench while the link runs
	assign link_data_input_pin = pin_level;

	// strobe halves of 4 or 12 clocks; it stands still outside a run
	always @(posedge aclk) begin
		if (!run) begin
			link_bit_strobe <= 1'h0;
			cnt <= 0;
			seen_bits <= '1;
		end else if (cnt >= (slow ? 11 : 3)) begin
			cnt <= 0;
			link_bit_strobe <= !link_bit_strobe;
			// previous slot's bit has settled by the next rising strobe
			if (!link_bit_strobe) begin
				seen_bits <= {seen_bits[62:0], link_data_out};
			end
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule // fhbr_link_partner
`default_nettype wire

// >>> bench/fhbr_top_tb.sv
// self-checking bench: register map, rx fifo, tx stream, code and irq
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
	$display("unexpected %s: expected %0h seen %0h", n, e, g); \
	fails++; end end
module fhbr_top_tb
	import fhbr_pkg::*;
;
	// clock, reset and bus master drive
	logic        aclk    = 1'h0;
	logic        aresetn = 1'h0;
	logic        aw_v    = 1'h0;
	logic        w_v     = 1'h0;
	logic        b_r     = 1'h0;
	logic        ar_v    = 1'h0;
	logic        r_r     = 1'h0;
	logic [7:0]  aw_a    = 8'h00;
	logic [7:0]  ar_a    = 8'h00;
	logic [31:0] w_d     = 32'h0;
	// design answers and partner side
	logic        aw_rdy, w_rdy, b_v, ar_rdy, r_v, irq, strobe, pin, lout;
	logic [1:0]  b_resp, r_resp, r;
	logic [31:0] r_d;
	logic [63:0] seen;
	logic [7:0]  d;
	logic        run     = 1'h0;
	logic        slow    = 1'h0;
	logic        pin_lvl = 1'h1;
	int          fails = 0;
	int          num_checks = 0;
	int          cycles = 0;

	fhbr_top fhbr_top_inst (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awvalid(aw_v), .s_axi_awready(aw_rdy), .s_axi_awaddr(aw_a),
		.s_axi_wvalid(w_v), .s_axi_wready(w_rdy), .s_axi_wdata(w_d),
		.s_axi_wstrb(4'hF), .s_axi_bvalid(b_v), .s_axi_bready(b_r),
		.s_axi_bresp(b_resp), .s_axi_arvalid(ar_v), .s_axi_arready(ar_rdy),
		.s_axi_araddr(ar_a), .s_axi_rvalid(r_v), .s_axi_rready(r_r),
		.s_axi_rdata(r_d), .s_axi_rresp(r_resp), .link_bit_strobe(strobe),
		.link_data_input_pin(pin), .link_data_out(lout), .irq(irq));

	fhbr_link_partner fhbr_link_partner_inst (.aclk(aclk), .run(run),
		.slow(slow), .pin_level(pin_lvl), .link_data_out(lout),
		.link_bit_strobe(strobe), .link_data_input_pin(pin),
		.seen_bits(seen));

	// 100 MHz clock
	initial begin
		forever #5 aclk = ~aclk;
	end

	// hang guard
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 9000) begin
			fails++;
			finish_test();
		end
	end

	// verdict and end of run
	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// one write: address and data offered together, each released when taken
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		bit ad;
		bit dd;
		ad = 0;
		dd = 0;
		@(posedge aclk);
		aw_v <= 1'h1;
		aw_a <= {a[5:0], 2'b00}; // byte address of the index
		w_v <= 1'h1;
		w_d <= {24'h0, v};
		b_r <= 1'h1;
		do begin
			@(posedge aclk);
			if (aw_rdy && !ad) begin
				ad = 1;
				aw_v <= 1'h0;
			end
			if (w_rdy && !dd) begin
				dd = 1;
				w_v <= 1'h0;
			end
		end while (!b_v);
		r = b_resp;
		b_r <= 1'h0;
	endtask

	// one read: result lands in d and r
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		ar_v <= 1'h1;
		ar_a <= {a[5:0], 2'b00}; // byte address of the index
		r_r <= 1'h1;
		do @(posedge aclk); while (!ar_rdy);
		ar_v <= 1'h0;
		do @(posedge aclk); while (!r_v);
		d = r_d[7:0];
		r = r_resp;
		r_r <= 1'h0;
	endtask

	// search the captured stream for a pattern of w bits
	function automatic bit has(input logic [63:0] p, input int w);
		logic [63:0] m;
		m = (64'h1 << w) - 64'h1;
		for (int i = 0; i <= 64 - w; i++) begin
			if (((seen >> i) & m) === p) return 1'h1;
		end
		return 1'h0;
	endfunction

	task automatic t_map();
		rd(FHBR_IDX_TX_STATUS);
		`CHK("idle status", 3'h4, d[2:0])
		`CHK("status resp", FHBR_RESP_OKAY, r)
		rd(FHBR_IDX_TX_CODE);
		`CHK("code reset", FHBR_CODE_RST, d)
		wr(FHBR_IDX_TX_CODE, 8'h3A);
		rd(FHBR_IDX_TX_CODE);
		`CHK("code readback", 8'h3A, d)
		wr(FHBR_IDX_TX_CODE, 8'h00);
		rd(8'h20);
		`CHK("unmapped read", FHBR_RESP_SLVERR, r)
		wr(8'h20, 8'h55);
		`CHK("unmapped write", FHBR_RESP_SLVERR, r)
		$display("test map finished");
	endtask

	task automatic t_rx();
		wr(FHBR_IDX_RX_PUSH, 8'h81);
		wr(FHBR_IDX_RX_PUSH, 8'h5C);
		rd(FHBR_IDX_RX_FIFO);
		`CHK("rx first byte", 8'h81, d)
		rd(FHBR_IDX_RX_FIFO);
		`CHK("rx second byte", 8'h5C, d)
		rd(FHBR_IDX_RX_FIFO);
		wr(FHBR_IDX_RX_PUSH, 8'h3E);
		rd(FHBR_IDX_RX_FIFO);
		`CHK("rx after empty read", 8'h3E, d)
		$display("test rx finished");
	endtask

	task automatic t_fill_drain();
		for (int i = 0; i < 15; i++) wr(FHBR_IDX_TX_FIFO, 8'(i));
		rd(FHBR_IDX_TX_STATUS);
		`CHK("status 15 bytes", 3'h0, d[2:0])
		wr(FHBR_IDX_TX_FIFO, 8'hFF);
		rd(FHBR_IDX_TX_STATUS);
		`CHK("status full", 3'h2, d[2:0])
		wr(FHBR_IDX_TX_CODE, 8'h40);
		run <= 1'h1;
		repeat (1400) @(posedge aclk);
		`CHK("irq masked", 1'h0, irq)
		wr(FHBR_IDX_IRQ_MASK, 8'h01);
		repeat (3) @(posedge aclk);
		`CHK("irq unmasked", 1'h1, irq)
		rd(FHBR_IDX_IRQ_STATUS);
		`CHK("irq underrun bit", 1'h1, d[0])
		repeat (3) @(posedge aclk);
		`CHK("irq cleared", 1'h0, irq)
		wr(FHBR_IDX_IRQ_MASK, 8'h00);
		rd(FHBR_IDX_TX_STATUS);
		`CHK("status underrun", 3'h5, d[2:0])
		rd(FHBR_IDX_TX_STATUS);
		`CHK("underrun cleared", 3'h4, d[2:0])
		$display("test fill and drain finished");
	endtask

	task automatic t_packet();
		wr(FHBR_IDX_TX_FIFO, 8'h0B);
		repeat (300) @(posedge aclk);
		`CHK("byte lsb first then abort", 1'h1, has(64'hD0FF, 16))
		rd(FHBR_IDX_TX_STATUS);
		`CHK("underrun held", 3'h5, d[2:0])
		$display("test packet finished");
	endtask

	task automatic t_code();
		slow <= 1'h1;
		wr(FHBR_IDX_TX_CODE, 8'h45);
		wr(FHBR_IDX_TX_CODE, 8'hC5);
		repeat (700) @(posedge aclk);
		`CHK("code on link", 1'h1, has(64'hD1, 8))
		`CHK("code not repeated", 1'h0, has(64'hA28, 12))
		rd(FHBR_IDX_TX_CODE);
		`CHK("code reg", 8'hC5, d)
		repeat (900) @(posedge aclk);
		`CHK("code sent once", 32'hFFFFFFFF, seen[31:0])
		$display("test code finished");
	endtask

	task automatic t_source();
		slow <= 1'h0;
		pin_lvl <= 1'h0;
		wr(FHBR_IDX_TX_CODE, 8'h05);
		repeat (300) @(posedge aclk);
		`CHK("pin low passed", 16'h0000, seen[15:0])
		pin_lvl <= 1'h1;
		repeat (300) @(posedge aclk);
		`CHK("pin high passed", 16'hFFFF, seen[15:0])
		pin_lvl <= 1'h0;
		wr(FHBR_IDX_TX_CODE, 8'h40);
		repeat (300) @(posedge aclk);
		`CHK("onboard idle", 16'hFFFF, seen[15:0])
		$display("test source finished");
	endtask

	// reset for 5 clocks, then the scenarios
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'h1;
		t_map();
		t_rx();
		t_fill_drain();
		t_packet();
		t_code();
		t_source();
		finish_test();
	end
endmodule // fhbr_top_tb
`default_nettype wire
